// [inc/efmc_map.vh]
// Register map, field positions, reset values and sizes of the encoder
// freeze and marker capture block.
// Assumes byte addressing on an 8-bit register address, one word each.
`ifndef EFMC_MAP_VH
`define EFMC_MAP_VH

// ----------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------
`define EFMC_CTRL_OFS        8'h00
`define EFMC_FLAGS_OFS       8'h04
`define EFMC_REF_FRZ_POS_OFS 8'h08
`define EFMC_REF_FRZ_REV_OFS 8'h0c
`define EFMC_FB_FRZ_POS_OFS  8'h10
`define EFMC_FB_FRZ_REV_OFS  8'h14
`define EFMC_REF_MRK_POS_OFS 8'h18
`define EFMC_REF_MRK_REV_OFS 8'h1c
`define EFMC_FB_MRK_POS_OFS  8'h20
`define EFMC_FB_MRK_REV_OFS  8'h24

// ----------------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------------
`define EFMC_CTRL_FRZ_EN     0
`define EFMC_CTRL_EDGE_FALL  1
`define EFMC_CTRL_EXT_SRC    2
`define EFMC_CTRL_SHARE_ACC  3
`define EFMC_CTRL_WIDTH      4
`define EFMC_CTRL_RESET      4'h0

// ----------------------------------------------------------------------
// Flag register fields
// ----------------------------------------------------------------------
`define EFMC_FLAG_REF_FRZ    0
`define EFMC_FLAG_FB_FRZ     1
`define EFMC_FLAG_REF_MRK    2
`define EFMC_FLAG_FB_MRK     3

// ----------------------------------------------------------------------
// Sizes
// ----------------------------------------------------------------------
`define EFMC_DATA_W          32
`define EFMC_ADDR_W          8
`define EFMC_POS_W           32
`define EFMC_REV_W           16

`endif

// [src/efmc_sync_edge.v]
// Two-stage synchroniser for one asynchronous pin and an edge detector
// on the synchronised level.
// Assumes the pin may change at any time relative to clk_sys_i.
`timescale 1ns/1ps

module efmc_sync_edge (
    // Clock and reset
    input  wire clk_sys_i,
    input  wire rst_i,
    // Pin and detected edges
    input  wire pin_i,
    output wire rise_o,
    output wire fall_o
);

    // ------------------------------------------------------------------
    // Synchroniser and edge history
    // ------------------------------------------------------------------
    reg meta;
    reg sync;
    reg prev;

    // The first stage is read only by the second stage.
    always @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            meta <= 1'b0;
            sync <= 1'b0;
            prev <= 1'b0;
        end else begin
            meta <= pin_i;
            sync <= meta;
            prev <= sync;
        end
    end

    // One-cycle pulses for each clean transition.
    assign rise_o = sync & ~prev;
    assign fall_o = ~sync & prev;

endmodule // efmc_sync_edge

// [src/efmc_capture.v]
// Freeze and marker capture registers and flags for one encoder.
// Assumes position and revolution count arrive on clk_sys_i unregistered
// by any other domain.
`timescale 1ns/1ps

module efmc_capture #(
    parameter POS_W = 32,
    parameter REV_W = 16
) (
    // Clock and reset
    input  wire             clk_sys_i,
    input  wire             rst_i,
    // Live encoder counters
    input  wire [POS_W-1:0] pos_i,
    input  wire [REV_W-1:0] rev_i,
    // Events and control
    input  wire             frz_evt_i,
    input  wire             frz_en_i,
    input  wire             frz_clr_i,
    input  wire             mrk_evt_i,
    input  wire             mrk_clr_i,
    // Captured values and flags
    output reg  [POS_W-1:0] frz_pos_o,
    output reg  [REV_W-1:0] frz_rev_o,
    output reg              frz_flag_o,
    output reg  [POS_W-1:0] mrk_pos_o,
    output reg  [REV_W-1:0] mrk_rev_o,
    output reg              mrk_flag_o
);

    // ------------------------------------------------------------------
    // Capture qualification
    // ------------------------------------------------------------------
    wire frz_take;

    // A pending freeze flag blocks new freeze data until it is cleared.
    assign frz_take = frz_evt_i & frz_en_i & ~frz_flag_o;

    // ------------------------------------------------------------------
    // Capture registers
    // ------------------------------------------------------------------
    // Position and revolution count latch in the same edge; a flag set
    // beats a clear arriving in the same cycle.
    always @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            frz_pos_o  <= {POS_W{1'b0}};
            frz_rev_o  <= {REV_W{1'b0}};
            frz_flag_o <= 1'b0;
            mrk_pos_o  <= {POS_W{1'b0}};
            mrk_rev_o  <= {REV_W{1'b0}};
            mrk_flag_o <= 1'b0;
        end else begin
            if (frz_take) begin
                frz_pos_o  <= pos_i;
                frz_rev_o  <= rev_i;
                frz_flag_o <= 1'b1;
            end else if (frz_clr_i) begin
                frz_flag_o <= 1'b0;
            end
            if (mrk_evt_i) begin
                mrk_pos_o  <= pos_i;
                mrk_rev_o  <= rev_i;
                mrk_flag_o <= 1'b1;
            end else if (mrk_clr_i) begin
                mrk_flag_o <= 1'b0;
            end
        end
    end

endmodule // efmc_capture

// [src/efmc_top.v]
// Top of the encoder freeze and marker capture block: freeze source
// selection, edge selection, register port and the two encoder channels.
// Assumes freeze and marker pins are asynchronous, encoder counters and
// the register port run on clk_sys_i.
//
// Implementation choices: the plain strobed port and the address map.
`timescale 1ns/1ps
`include "efmc_map.vh"

// Contract
// - Local freeze input captures both reference and feedback counters.
// - Reference freeze stores revolution count and position in own registers.
// - Feedback freeze stores revolution count and position in own registers.
// - Variant without local freeze takes shared freeze once sharing accepted.
// - Expansion encoder source takes freeze from the expansion module.
// - Edge select 0 captures on rising edge, 1 on falling edge.
// - Freeze results are written only while freeze enable is set.
// - Detected freeze sets both freeze flags and stores data with them; here a channel whose freeze flag is still set keeps its old data.
// - Marker captures position and revolutions per encoder independently.
// - Marker position and count stored in separate registers per encoder.
// - Marker sets its flag every time; software clears it after reading.
module efmc_top #(
    parameter POS_W            = `EFMC_POS_W,
    parameter REV_W            = `EFMC_REV_W,
    parameter HAS_LOCAL_FREEZE = 1
) (
    // Clock and reset
    input  wire                    clk_sys_i,
    input  wire                    rst_i,
    // Freeze sources
    input  wire                    freeze_digital_input_i,
    input  wire                    shared_freeze_i,
    input  wire                    expansion_freeze_i,
    // Marker pins
    input  wire                    ref_marker_i,
    input  wire                    fb_marker_i,
    // Live encoder counters
    input  wire [POS_W-1:0]        ref_pos_i,
    input  wire [REV_W-1:0]        ref_rev_i,
    input  wire [POS_W-1:0]        fb_pos_i,
    input  wire [REV_W-1:0]        fb_rev_i,
    // Register port
    input  wire [`EFMC_ADDR_W-1:0] addr_i,
    input  wire [`EFMC_DATA_W-1:0] wr_data_i,
    input  wire                    wr_i,
    input  wire                    rd_i,
    output reg  [`EFMC_DATA_W-1:0] rd_data_o,
    // Status
    output wire                    ref_frz_flag_o,
    output wire                    fb_frz_flag_o,
    output wire                    ref_mrk_flag_o,
    output wire                    fb_mrk_flag_o
);

    // ------------------------------------------------------------------
    // Helper functions
    // ------------------------------------------------------------------
    // Widens a position value to the register word, zero filled.
    function [`EFMC_DATA_W-1:0] pos_word;
        input [POS_W-1:0] v;
        begin
            pos_word = {`EFMC_DATA_W{1'b0}};
            pos_word[POS_W-1:0] = v;
        end
    endfunction

    // Widens a revolution count to the register word, zero filled.
    function [`EFMC_DATA_W-1:0] rev_word;
        input [REV_W-1:0] v;
        begin
            rev_word = {`EFMC_DATA_W{1'b0}};
            rev_word[REV_W-1:0] = v;
        end
    endfunction

    // Address match for a write of the given offset.
    function wr_hit;
        input                    strobe;
        input [`EFMC_ADDR_W-1:0] a;
        input [`EFMC_ADDR_W-1:0] ofs;
        begin
            wr_hit = strobe & (a == ofs);
        end
    endfunction

    // ------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------
    reg  [`EFMC_CTRL_WIDTH-1:0] ctrl;
    wire                        frz_en;
    wire                        edge_fall;
    wire                        ext_src;
    wire                        share_acc;

    wire loc_rise;
    wire loc_fall;
    wire shr_rise;
    wire shr_fall;
    wire exp_rise;
    wire exp_fall;
    wire ref_mrk_rise;
    wire fb_mrk_rise;

    reg  sel_rise;
    reg  sel_fall;
    wire frz_evt;

    wire flags_wr;
    wire ref_frz_clr;
    wire fb_frz_clr;
    wire ref_mrk_clr;
    wire fb_mrk_clr;

    wire [POS_W-1:0] ref_frz_pos;
    wire [REV_W-1:0] ref_frz_rev;
    wire [POS_W-1:0] fb_frz_pos;
    wire [REV_W-1:0] fb_frz_rev;
    wire [POS_W-1:0] ref_mrk_pos;
    wire [REV_W-1:0] ref_mrk_rev;
    wire [POS_W-1:0] fb_mrk_pos;
    wire [REV_W-1:0] fb_mrk_rev;

    reg  [`EFMC_DATA_W-1:0] next_rd_data;

    // ------------------------------------------------------------------
    // Control register
    // ------------------------------------------------------------------
    // Holds freeze enable, edge select, source select and share accept.
    always @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            ctrl <= `EFMC_CTRL_RESET;
        end else if (wr_hit(wr_i, addr_i, `EFMC_CTRL_OFS)) begin
            ctrl <= wr_data_i[`EFMC_CTRL_WIDTH-1:0];
        end
    end

    // Named views of the control fields.
    assign frz_en    = ctrl[`EFMC_CTRL_FRZ_EN];
    assign edge_fall = ctrl[`EFMC_CTRL_EDGE_FALL];
    assign ext_src   = ctrl[`EFMC_CTRL_EXT_SRC];
    assign share_acc = ctrl[`EFMC_CTRL_SHARE_ACC];

    // ------------------------------------------------------------------
    // Pin synchronisers and edge detectors
    // ------------------------------------------------------------------
    // Local freeze pin.
    efmc_sync_edge u_sync_loc (
        .clk_sys_i (clk_sys_i),
        .rst_i     (rst_i),
        .pin_i     (freeze_digital_input_i),
        .rise_o    (loc_rise),
        .fall_o    (loc_fall)
    );

    // Freeze shared by another module of the same drive.
    efmc_sync_edge u_sync_shr (
        .clk_sys_i (clk_sys_i),
        .rst_i     (rst_i),
        .pin_i     (shared_freeze_i),
        .rise_o    (shr_rise),
        .fall_o    (shr_fall)
    );

    // Freeze from the encoder expansion module.
    efmc_sync_edge u_sync_exp (
        .clk_sys_i (clk_sys_i),
        .rst_i     (rst_i),
        .pin_i     (expansion_freeze_i),
        .rise_o    (exp_rise),
        .fall_o    (exp_fall)
    );

    // Reference encoder marker; only its rising edge marks.
    efmc_sync_edge u_sync_rmk (
        .clk_sys_i (clk_sys_i),
        .rst_i     (rst_i),
        .pin_i     (ref_marker_i),
        .rise_o    (ref_mrk_rise),
        .fall_o    ()
    );

    // Feedback encoder marker; only its rising edge marks.
    efmc_sync_edge u_sync_fmk (
        .clk_sys_i (clk_sys_i),
        .rst_i     (rst_i),
        .pin_i     (fb_marker_i),
        .rise_o    (fb_mrk_rise),
        .fall_o    ()
    );

    // ------------------------------------------------------------------
    // Freeze source and edge selection
    // ------------------------------------------------------------------
    // Sources are chosen after edge detection, so a source switch never
    // makes a false edge out of two different levels.
    always @* begin
        sel_rise = 1'b0;
        sel_fall = 1'b0;
        if (ext_src) begin
            sel_rise = exp_rise;
            sel_fall = exp_fall;
        end else if (HAS_LOCAL_FREEZE != 0) begin
            sel_rise = loc_rise;
            sel_fall = loc_fall;
        end else if (share_acc) begin
            sel_rise = shr_rise;
            sel_fall = shr_fall;
        end
    end

    // One freeze event drives both encoder channels in the same cycle.
    assign frz_evt = edge_fall ? sel_fall : sel_rise;

    // ------------------------------------------------------------------
    // Flag clear decode
    // ------------------------------------------------------------------
    // Writing zero to a flag bit clears it; writing one leaves it alone.
    assign flags_wr    = wr_hit(wr_i, addr_i, `EFMC_FLAGS_OFS);
    assign ref_frz_clr = flags_wr & ~wr_data_i[`EFMC_FLAG_REF_FRZ];
    assign fb_frz_clr  = flags_wr & ~wr_data_i[`EFMC_FLAG_FB_FRZ];
    assign ref_mrk_clr = flags_wr & ~wr_data_i[`EFMC_FLAG_REF_MRK];
    assign fb_mrk_clr  = flags_wr & ~wr_data_i[`EFMC_FLAG_FB_MRK];

    // ------------------------------------------------------------------
    // Encoder channels
    // ------------------------------------------------------------------
    // Reference encoder captures.
    efmc_capture #(
        .POS_W (POS_W),
        .REV_W (REV_W)
    ) u_ref (
        .clk_sys_i  (clk_sys_i),
        .rst_i      (rst_i),
        .pos_i      (ref_pos_i),
        .rev_i      (ref_rev_i),
        .frz_evt_i  (frz_evt),
        .frz_en_i   (frz_en),
        .frz_clr_i  (ref_frz_clr),
        .mrk_evt_i  (ref_mrk_rise),
        .mrk_clr_i  (ref_mrk_clr),
        .frz_pos_o  (ref_frz_pos),
        .frz_rev_o  (ref_frz_rev),
        .frz_flag_o (ref_frz_flag_o),
        .mrk_pos_o  (ref_mrk_pos),
        .mrk_rev_o  (ref_mrk_rev),
        .mrk_flag_o (ref_mrk_flag_o)
    );

    // Feedback encoder captures.
    efmc_capture #(
        .POS_W (POS_W),
        .REV_W (REV_W)
    ) u_fb (
        .clk_sys_i  (clk_sys_i),
        .rst_i      (rst_i),
        .pos_i      (fb_pos_i),
        .rev_i      (fb_rev_i),
        .frz_evt_i  (frz_evt),
        .frz_en_i   (frz_en),
        .frz_clr_i  (fb_frz_clr),
        .mrk_evt_i  (fb_mrk_rise),
        .mrk_clr_i  (fb_mrk_clr),
        .frz_pos_o  (fb_frz_pos),
        .frz_rev_o  (fb_frz_rev),
        .frz_flag_o (fb_frz_flag_o),
        .mrk_pos_o  (fb_mrk_pos),
        .mrk_rev_o  (fb_mrk_rev),
        .mrk_flag_o (fb_mrk_flag_o)
    );

    // ------------------------------------------------------------------
    // Read decode
    // ------------------------------------------------------------------
    // Unmapped offsets and unused bits read as zero.
    always @* begin
        next_rd_data = {`EFMC_DATA_W{1'b0}};
        if (rd_i) begin
            case (addr_i)
                `EFMC_CTRL_OFS: begin
                    next_rd_data[`EFMC_CTRL_WIDTH-1:0] = ctrl;
                end
                `EFMC_FLAGS_OFS: begin
                    next_rd_data[`EFMC_FLAG_REF_FRZ] = ref_frz_flag_o;
                    next_rd_data[`EFMC_FLAG_FB_FRZ]  = fb_frz_flag_o;
                    next_rd_data[`EFMC_FLAG_REF_MRK] = ref_mrk_flag_o;
                    next_rd_data[`EFMC_FLAG_FB_MRK]  = fb_mrk_flag_o;
                end
                `EFMC_REF_FRZ_POS_OFS: begin
                    next_rd_data = pos_word(ref_frz_pos);
                end
                `EFMC_REF_FRZ_REV_OFS: begin
                    next_rd_data = rev_word(ref_frz_rev);
                end
                `EFMC_FB_FRZ_POS_OFS: begin
                    next_rd_data = pos_word(fb_frz_pos);
                end
                `EFMC_FB_FRZ_REV_OFS: begin
                    next_rd_data = rev_word(fb_frz_rev);
                end
                `EFMC_REF_MRK_POS_OFS: begin
                    next_rd_data = pos_word(ref_mrk_pos);
                end
                `EFMC_REF_MRK_REV_OFS: begin
                    next_rd_data = rev_word(ref_mrk_rev);
                end
                `EFMC_FB_MRK_POS_OFS: begin
                    next_rd_data = pos_word(fb_mrk_pos);
                end
                `EFMC_FB_MRK_REV_OFS: begin
                    next_rd_data = rev_word(fb_mrk_rev);
                end
                default: begin
                    next_rd_data = {`EFMC_DATA_W{1'b0}};
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Read data register
    // ------------------------------------------------------------------
    // Read data stand only in the cycle after the read strobe.
    always @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            rd_data_o <= {`EFMC_DATA_W{1'b0}};
        end else begin
            rd_data_o <= next_rd_data;
        end
    end

endmodule // efmc_top

// [tb/efmc_enc_model.sv]
// Behavioural incremental encoder feeding live position and turns.
// Assumes the speed input changes only just after a rising clock edge.
`timescale 1ns/1ps

module efmc_enc_model (
    // Clock, reset and speed
    input  wire logic        clk_sys_i,
    input  wire logic        rst_i,
    input  wire logic [31:0] step_i,
    // Live counters
    output logic      [31:0] pos_o,
    output logic      [15:0] rev_o
);
    // A carry out of the position bumps the turn count in the same cycle,
    // so a capture that splits the pair across cycles shows up at once.
    always @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            pos_o <= 32'h0;
            rev_o <= 16'h0;
        end else begin
            {rev_o, pos_o} <= {rev_o, pos_o} + {16'h0, step_i};
        end
    end
endmodule // efmc_enc_model

// [tb/efmc_checker.sv]
// Assertions on the ports of the freeze and marker capture top.
// Assumes one clock domain and the register map of the block.
`timescale 1ns/1ps
`include "efmc_map.vh"

module efmc_checker (
    // Clock and reset
    input wire                    clk_sys_i,
    input wire                    rst_i,
    // Pins
    input wire                    freeze_digital_input_i,
    input wire                    expansion_freeze_i,
    input wire                    ref_marker_i,
    input wire                    fb_marker_i,
    // Register port
    input wire [`EFMC_ADDR_W-1:0] addr_i,
    input wire [`EFMC_DATA_W-1:0] wr_data_i,
    input wire                    wr_i,
    input wire                    rd_i,
    input wire [`EFMC_DATA_W-1:0] rd_data_o,
    // Flags
    input wire                    ref_frz_flag_o,
    input wire                    fb_frz_flag_o,
    input wire                    ref_mrk_flag_o,
    input wire                    fb_mrk_flag_o
);
    logic [3:0] ctrl;
    wire        clr_wr = wr_i && (addr_i == `EFMC_FLAGS_OFS);
    wire        src = ctrl[2] ? expansion_freeze_i : freeze_digital_input_i;

    default clocking cb @(posedge clk_sys_i);
    endclocking
    default disable iff (rst_i);

    // Shadow of the control word, taken from writes seen on the port.
    always @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i)
            ctrl <= 4'h0;
        else if (wr_i && (addr_i == `EFMC_CTRL_OFS))
            ctrl <= wr_data_i[3:0];
    end

    sequence s_frz_go;
        ctrl[0] && !ref_frz_flag_o && !fb_frz_flag_o
            && (ctrl[1] ? $fell(src) : $rose(src));
    endsequence
    sequence s_ref_mrk;
        $rose(ref_marker_i);
    endsequence
    sequence s_fb_mrk;
        $rose(fb_marker_i);
    endsequence

    property p_frz_go;
        s_frz_go |-> ##3 (ref_frz_flag_o && fb_frz_flag_o);
    endproperty
    property p_frz_en;
        $rose(ref_frz_flag_o) || $rose(fb_frz_flag_o) |-> $past(ctrl[0]);
    endproperty
    property p_frz_pair;
        $rose(ref_frz_flag_o) && !$past(fb_frz_flag_o) |-> fb_frz_flag_o;
    endproperty
    property p_frz_keep;
        ref_frz_flag_o && !clr_wr |=> ref_frz_flag_o;
    endproperty
    property p_mrk_ref;
        s_ref_mrk |-> ##3 ref_mrk_flag_o;
    endproperty
    property p_mrk_fb;
        s_fb_mrk |-> ##3 fb_mrk_flag_o;
    endproperty
    property p_mrk_keep;
        fb_mrk_flag_o && !clr_wr |=> fb_mrk_flag_o;
    endproperty
    property p_mrk_cause;
        $rose(ref_mrk_flag_o) |-> $past(ref_marker_i, 3);
    endproperty
    property p_rd_idle;
        !$past(rd_i) |-> rd_data_o == 32'h0;
    endproperty

    a_frz_go: assert property (p_frz_go)
        else $error("freeze edge did not set both freeze flags");
    a_frz_en: assert property (p_frz_en)
        else $error("freeze flag set while capture disabled");
    a_frz_pair: assert property (p_frz_pair)
        else $error("freeze flags did not set together");
    a_frz_keep: assert property (p_frz_keep)
        else $error("freeze flag dropped without a clear");
    a_mrk_ref: assert property (p_mrk_ref)
        else $error("reference marker flag not set");
    a_mrk_fb: assert property (p_mrk_fb)
        else $error("feedback marker flag not set");
    a_mrk_keep: assert property (p_mrk_keep)
        else $error("marker flag dropped without a clear");
    a_mrk_cause: assert property (p_mrk_cause)
        else $error("marker flag set with no marker");
    a_rd_idle: assert property (p_rd_idle)
        else $error("read data not zero outside a read");
endmodule // efmc_checker

bind efmc_top efmc_checker u_chk (
    .clk_sys_i              (clk_sys_i),
    .rst_i                  (rst_i),
    .freeze_digital_input_i (freeze_digital_input_i),
    .expansion_freeze_i     (expansion_freeze_i),
    .ref_marker_i           (ref_marker_i),
    .fb_marker_i            (fb_marker_i),
    .addr_i                 (addr_i),
    .wr_data_i              (wr_data_i),
    .wr_i                   (wr_i),
    .rd_i                   (rd_i),
    .rd_data_o              (rd_data_o),
    .ref_frz_flag_o         (ref_frz_flag_o),
    .fb_frz_flag_o          (fb_frz_flag_o),
    .ref_mrk_flag_o         (ref_mrk_flag_o),
    .fb_mrk_flag_o          (fb_mrk_flag_o)
);

// [tb/efmc_top_tb.sv]
// Self-checking bench for the freeze and marker capture top.
// Assumes the register map header and two encoder models beside it.
`timescale 1ns/1ps
`include "efmc_map.vh"

module efmc_top_tb;
    logic        clk_sys_i;
    logic        rst_i;
    logic [4:0]  pin;
    logic [7:0]  addr;
    logic [31:0] wdat;
    logic        wr_en, rd_en, pend;
    logic [31:0] step_r, step_f, rpos, fpos, rd_data, exp_v, s_rp, s_fp;
    logic [15:0] rrev, frev, s_rr, s_fr;
    logic [31:0] fzp[2], mkp[2];
    logic [15:0] fzr[2], mkr[2];
    logic [3:0]  fl, flg;
    logic [15:0] lf;
    logic [31:0] expq[$];
    int          bad_count, samples_checked;

    efmc_enc_model u_ref (.clk_sys_i(clk_sys_i), .rst_i(rst_i),
        .step_i(step_r), .pos_o(rpos), .rev_o(rrev));
    efmc_enc_model u_fb (.clk_sys_i(clk_sys_i), .rst_i(rst_i),
        .step_i(step_f), .pos_o(fpos), .rev_o(frev));
    efmc_top u_dut (.clk_sys_i(clk_sys_i), .rst_i(rst_i),
        .freeze_digital_input_i(pin[0]), .shared_freeze_i(pin[1]),
        .expansion_freeze_i(pin[2]), .ref_marker_i(pin[3]),
        .fb_marker_i(pin[4]), .ref_pos_i(rpos), .ref_rev_i(rrev),
        .fb_pos_i(fpos), .fb_rev_i(frev), .addr_i(addr),
        .wr_data_i(wdat), .wr_i(wr_en), .rd_i(rd_en), .rd_data_o(rd_data),
        .ref_frz_flag_o(flg[0]), .fb_frz_flag_o(flg[1]),
        .ref_mrk_flag_o(flg[2]), .fb_mrk_flag_o(flg[3]));

    // Clock of 100 ns period.
    initial begin
        clk_sys_i = 1'b0;
        forever #50 clk_sys_i = ~clk_sys_i;
    end

    function automatic logic [15:0] nx(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction

    // Read results land one cycle after the strobe; compare the oldest note.
    always @(negedge clk_sys_i) begin
        if (pend) begin
            exp_v = expq.pop_front();
            samples_checked++;
            if (rd_data !== exp_v) begin
                bad_count++;
                $display("MISMATCH at %0t: read %h, want %h", $time,
                         rd_data, exp_v);
            end
        end
        pend = rd_en;
    end

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys_i);
        addr  <= a;
        wdat  <= d;
        wr_en <= 1'b1;
        @(posedge clk_sys_i);
        wr_en <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        expq.push_back(e);
        @(posedge clk_sys_i);
        addr  <= a;
        rd_en <= 1'b1;
        @(posedge clk_sys_i);
        rd_en <= 1'b0;
    endtask

    // Moves one pin and notes the counters that a capture should hold.
    task automatic pin_to(input int p, input logic v);
        @(posedge clk_sys_i);
        pin[p] <= v;
        repeat (2) @(posedge clk_sys_i);
        #1;
        {s_rp, s_rr, s_fp, s_fr} = {rpos, rrev, fpos, frev};
        repeat (4) @(posedge clk_sys_i);
    endtask

    task automatic take(input logic r, input logic f);
        if (r) {fzp[0], fzr[0], fl[0]} = {s_rp, s_rr, 1'b1};
        if (f) {fzp[1], fzr[1], fl[1]} = {s_fp, s_fr, 1'b1};
    endtask

    task automatic check();
        rd(`EFMC_FLAGS_OFS, {28'h0, fl});
        samples_checked++;
        if (flg !== fl) begin
            bad_count++;
            $display("MISMATCH at %0t: flag pins %h, want %h", $time, flg, fl);
        end
        rd(`EFMC_REF_FRZ_POS_OFS, fzp[0]);
        rd(`EFMC_REF_FRZ_REV_OFS, {16'h0, fzr[0]});
        rd(`EFMC_FB_FRZ_POS_OFS, fzp[1]);
        rd(`EFMC_FB_FRZ_REV_OFS, {16'h0, fzr[1]});
        rd(`EFMC_REF_MRK_POS_OFS, mkp[0]);
        rd(`EFMC_REF_MRK_REV_OFS, {16'h0, mkr[0]});
        rd(`EFMC_FB_MRK_POS_OFS, mkp[1]);
        rd(`EFMC_FB_MRK_REV_OFS, {16'h0, mkr[1]});
    endtask

    task automatic clear_model();
        {fl, fzp[0], fzp[1], mkp[0], mkp[1], fzr[0], fzr[1]} = '0;
        {mkr[0], mkr[1]} = '0;
    endtask

    task automatic end_sim();
        $display("Compared %0d, mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    // Watchdog far beyond the few hundred cycles the run needs.
    initial begin
        #2000000;
        bad_count++;
        $display("MISMATCH at %0t: run did not finish", $time);
        end_sim();
    end

    // Main sequence.
    initial begin
        {pin, addr, wdat, wr_en, rd_en, pend} = '0;
        lf = 16'h0038;
        step_r = 32'h0;
        step_f = 32'h0;
        clear_model();
        rst_i = 1'b1;
        repeat (10) @(posedge clk_sys_i);
        rst_i  <= 1'b0;
        lf = nx(lf);
        step_r <= {lf, ~lf};
        lf = nx(lf);
        step_f <= {~lf, lf};
        check();
        rd(`EFMC_CTRL_OFS, 32'h0);
        wr(8'hfc, 32'hffffffff);
        rd(8'hfc, 32'h0);
        pin_to(0, 1'b1);
        check();
        pin_to(0, 1'b0);
        wr(`EFMC_CTRL_OFS, 32'h1);
        pin_to(0, 1'b1);
        take(1'b1, 1'b1);
        check();
        wr(`EFMC_FLAGS_OFS, 32'h0);
        fl[1:0] = 2'b00;
        pin_to(0, 1'b0);
        check();
        wr(`EFMC_CTRL_OFS, 32'h3);
        pin_to(0, 1'b1);
        check();
        pin_to(0, 1'b0);
        take(1'b1, 1'b1);
        check();
        pin_to(0, 1'b1);
        pin_to(0, 1'b0);
        check();
        wr(`EFMC_FLAGS_OFS, 32'he);
        fl[0] = 1'b0;
        pin_to(0, 1'b1);
        pin_to(0, 1'b0);
        take(1'b1, 1'b0);
        check();
        wr(`EFMC_FLAGS_OFS, 32'h0);
        fl[1:0] = 2'b00;
        wr(`EFMC_CTRL_OFS, 32'h5);
        pin_to(0, 1'b1);
        check();
        pin_to(2, 1'b1);
        take(1'b1, 1'b1);
        check();
        pin_to(0, 1'b0);
        pin_to(2, 1'b0);
        for (int i = 0; i < 3; i++) begin
            lf = nx(lf);
            step_r <= {lf, lf};
            pin_to(3, 1'b1);
            {mkp[0], mkr[0], fl[2]} = {s_rp, s_rr, 1'b1};
            pin_to(3, 1'b0);
            if (i > 0) begin
                pin_to(4, 1'b1);
                {mkp[1], mkr[1], fl[3]} = {s_fp, s_fr, 1'b1};
                pin_to(4, 1'b0);
            end
            check();
        end
        wr(`EFMC_FLAGS_OFS, 32'hb);
        fl[2] = 1'b0;
        check();
        @(posedge clk_sys_i);
        rst_i <= 1'b1;
        repeat (2) @(posedge clk_sys_i);
        rst_i <= 1'b0;
        clear_model();
        check();
        rd(`EFMC_CTRL_OFS, 32'h0);
        end_sim();
    end
endmodule // efmc_top_tb
